//--- hw/rft_ctrl.sv
// Top of the boot ROM/Flash access timing controller
`timescale 1ns/1ps
module rft_ctrl (
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic START,
	input wire logic BLOCK_SEL,
	input wire logic WRITE,
	input wire logic BURST,
	input wire logic [3:0] SIZE,
	input wire logic [4:0] ACC_A,
	input wire logic [4:0] ACC_B,
	input wire logic WIDE_A,
	input wire logic WIDE_B,
	output logic BUSY,
	output logic ACK,
	output logic LAST,
	output logic ERROR,
	output logic DEV_RD,
	output logic DEV_WR
);
	typedef enum logic [1:0] {S_IDLE, S_READ, S_WRITE} rft_state_t;
	rft_state_t state_q, state_d;
	logic [1:0] beat_q;
	logic burst_q, wide_q, busy_q, ack_q, last_q, err_q, dev_rd_q, dev_wr_q;
	logic [4:0] acc_q;
	logic [7:0] load_cnt;
	logic tmr_load, tmr_done;

	// ----------------------------------------
	// Request decode
	// ----------------------------------------
	wire [4:0] acc_sel = BLOCK_SEL ? ACC_B : ACC_A;
	wire wide_sel = BLOCK_SEL ? WIDE_B : WIDE_A;
	// A single byte needs one device cycle, so it costs like a wide block
	wire eff_wide = wide_sel || (!BURST && SIZE == 4'h1);
	wire bad_req = WRITE && BURST;
	wire take = START && state_q == S_IDLE;
	wire [7:0] acc8 = {3'h0, acc_sel};
	wire [7:0] acc8_q = {3'h0, acc_q};
	// Narrow beat = four device reads; first adds fixed start cost
	wire [7:0] narrow_beat = 8'(rft_pkg::NARROW_READS) * (acc8 + rft_pkg::DEV_OVH);
	wire [7:0] first_cnt = eff_wide ? acc8 + rft_pkg::FIRST_OVH : narrow_beat + rft_pkg::NARROW_OVH;
	wire [7:0] next_cnt = wide_q ? acc8_q + rft_pkg::NEXT_OVH
		: 8'(rft_pkg::NARROW_READS) * (acc8_q + rft_pkg::DEV_OVH);
	wire more = state_q == S_READ && tmr_done && burst_q && beat_q != rft_pkg::BURST_BEATS;
	assign tmr_load = (take && !bad_req) || more;
	assign load_cnt = take ? (WRITE ? rft_pkg::WRITE_CLOCKS : first_cnt) : next_cnt;

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			S_IDLE: if (take && !bad_req) state_d = WRITE ? S_WRITE : S_READ;
			S_READ: if (tmr_done && !more) state_d = S_IDLE;
			S_WRITE: if (tmr_done) state_d = S_IDLE;
		endcase
	end

	rft_beat_timer #(.W(8)) u_tmr (
		.clk(CLOCK),
		.rst_n(RESET_N),
		.load(tmr_load),
		.count(load_cnt),
		.done(tmr_done)
	);

	// ----------------------------------------
	// State and outputs
	// ----------------------------------------
	always_ff @(posedge CLOCK)
	begin
		if (!RESET_N)
		begin
			state_q <= S_IDLE;
			beat_q <= 2'h0;
			burst_q <= 1'b0;
			wide_q <= 1'b1;
			acc_q <= rft_pkg::ACC_RESET;
			busy_q <= 1'b0;
			ack_q <= 1'b0;
			last_q <= 1'b0;
			err_q <= 1'b0;
			dev_rd_q <= 1'b0;
			dev_wr_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			if (take)
			begin
				beat_q <= 2'h0;
				burst_q <= BURST;
				wide_q <= eff_wide;
				acc_q <= acc_sel;
			end
			else if (more)
				beat_q <= beat_q + 2'h1;
			busy_q <= state_d != S_IDLE;
			ack_q <= state_q != S_IDLE && tmr_done;
			last_q <= state_q != S_IDLE && tmr_done && !more;
			err_q <= take && bad_req;
			dev_rd_q <= state_d == S_READ;
			dev_wr_q <= state_d == S_WRITE;
		end
	end
	assign BUSY = busy_q;
	assign ACK = ack_q;
	assign LAST = last_q;
	assign ERROR = err_q;
	assign DEV_RD = dev_rd_q;
	assign DEV_WR = dev_wr_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);

	// ----------------------------------------
	// Helper: ACKs seen since the last take
	// ----------------------------------------
	// Counting beats here avoids a long repetition in the pairing checks
	logic [2:0] acks_q;
	always_ff @(posedge CLOCK)
	begin
		if (!RESET_N || take)
			acks_q <= 3'h0;
		else if (ack_q)
			acks_q <= acks_q + 3'h1;
	end

	// ----------------------------------------
	// First beat, counted from the take edge
	// ----------------------------------------
	// ACK is launched N edges after the take edge, so it is sampled one edge later
	AST_WRITE_21: assert property ((take && WRITE && !BURST)
		|=> ##21 ACK)
		else $error("write not 21");
	AST_WIDE12: assert property ((take && !WRITE && wide_sel && ACC_A == 5'h0c && !BLOCK_SEL)
		|=> ##22 ACK)
		else $error("wide first beat");
	AST_WIDE_B12: assert property ((take && !WRITE && eff_wide && ACC_B == 5'h0c && BLOCK_SEL)
		|=> ##22 ACK)
		else $error("block B wide first beat");
	AST_WIDE8: assert property ((take && !WRITE && eff_wide && acc_sel == 5'h08)
		|=> ##18 ACK)
		else $error("wide 8 clk");
	AST_WIDE5: assert property ((take && !WRITE && eff_wide && acc_sel == 5'h05)
		|=> ##15 ACK)
		else $error("wide 5 clk");
	AST_WIDE3: assert property ((take && !WRITE && eff_wide && acc_sel == 5'h03)
		|=> ##13 ACK)
		else $error("wide 3 clk");
	AST_NARROW12: assert property ((take && !WRITE && !eff_wide && acc_sel == 5'h0c)
		|=> ##70 ACK)
		else $error("narrow first beat");
	AST_NARROW8: assert property ((take && !WRITE && !eff_wide && acc_sel == 5'h08)
		|=> ##54 ACK)
		else $error("narrow 8 clk");
	AST_NARROW5: assert property ((take && !WRITE && !eff_wide && acc_sel == 5'h05)
		|=> ##42 ACK)
		else $error("narrow 5 clk");
	AST_NARROW3: assert property ((take && !WRITE && !eff_wide && acc_sel == 5'h03)
		|=> ##34 ACK)
		else $error("narrow 3 clk");

	// ----------------------------------------
	// Later beats, counted from the previous ACK
	// ----------------------------------------
	AST_NEXT: assert property ((ACK && !LAST && wide_q && acc_q == 5'h0c)
		|-> ##16 ACK)
		else $error("later beat");
	AST_NEXT8: assert property ((ACK && !LAST && wide_q && acc_q == 5'h08)
		|-> ##12 ACK)
		else $error("later beat 8 clk");
	AST_NEXT5: assert property ((ACK && !LAST && wide_q && acc_q == 5'h05)
		|-> ##9 ACK)
		else $error("later beat 5 clk");
	AST_NEXT3: assert property ((ACK && !LAST && wide_q && acc_q == 5'h03)
		|-> ##7 ACK)
		else $error("later beat 3 clk");
	AST_NEXT_N12: assert property ((ACK && !LAST && !wide_q && acc_q == 5'h0c)
		|-> ##64 ACK)
		else $error("narrow later beat");
	AST_NEXT_N8: assert property ((ACK && !LAST && !wide_q && acc_q == 5'h08)
		|-> ##48 ACK)
		else $error("narrow later beat 8 clk");
	AST_NEXT_N5: assert property ((ACK && !LAST && !wide_q && acc_q == 5'h05)
		|-> ##36 ACK)
		else $error("narrow later beat 5 clk");
	AST_NEXT_N3: assert property ((ACK && !LAST && !wide_q && acc_q == 5'h03)
		|-> ##28 ACK)
		else $error("narrow later beat 3 clk");

	// ----------------------------------------
	// Pairing, refusal and device strobes
	// ----------------------------------------
	AST_BURST_FOUR: assert property ((ACK && LAST && burst_q)
		|-> acks_q == 3'h3)
		else $error("burst did not end on its fourth beat");
	AST_SINGLE_ONE: assert property ((ACK && !burst_q)
		|-> LAST && acks_q == 3'h0)
		else $error("single transfer not one beat");
	AST_LAST_ACK: assert property (LAST
		|-> ACK)
		else $error("last without ack");
	AST_BURSTW: assert property ((take && bad_req)
		|=> ERROR && !BUSY)
		else $error("burst write taken");
	AST_REFUSE_QUIET: assert property ((take && bad_req)
		|=> !DEV_WR && !DEV_RD && !ACK)
		else $error("refused write reached the device");
	AST_ERR_ALONE: assert property (ERROR
		|-> !ACK && !BUSY)
		else $error("error during a transfer");
	AST_WRITE_DEV: assert property ((take && WRITE && !BURST)
		|=> DEV_WR && BUSY)
		else $error("write cycle not started");
	AST_DEV_RD: assert property (DEV_RD
		|-> BUSY && !DEV_WR)
		else $error("device read outside a transfer");
	AST_DEV_WR: assert property (DEV_WR
		|-> BUSY && !DEV_RD)
		else $error("device write outside a transfer");
	COV_BURST: cover property (ACK && LAST && burst_q);
	COV_WRITE: cover property (take && WRITE);
	COV_BYTE: cover property (take && !BURST && SIZE == 4'h1 && !wide_sel);
	COV_NARROW_BURST: cover property (ACK && LAST && burst_q && !wide_q);
	COV_REFUSE: cover property (ERROR);
endmodule // rft_ctrl

//--- hw/rft_pkg.sv
// Package of constants for the boot ROM/Flash access timing controller
package rft_pkg;
	// ----------------------------------------
	// Timing counts, in processor bus clocks
	// ----------------------------------------
	// First beat = access + 10, later beats = access + 4 (wide block)
	localparam logic [7:0] FIRST_OVH = 8'h0a;
	localparam logic [7:0] NEXT_OVH = 8'h04;
	// Narrow block: each of four device reads costs access + 4, plus a 6 clock start
	localparam logic [7:0] NARROW_OVH = 8'h06;
	localparam logic [7:0] DEV_OVH = 8'h04;
	localparam logic [7:0] WRITE_CLOCKS = 8'h15;
	localparam logic [1:0] BURST_BEATS = 2'h3;
	localparam int NARROW_READS = 4;
	localparam logic [4:0] ACC_RESET = 5'h0c;
endpackage

//--- hw/rft_beat_timer.sv
// Down counter that marks the end of one timed interval
`timescale 1ns/1ps
module rft_beat_timer #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [W-1:0] count,
	output logic done
);
	logic [W-1:0] cnt_q;
	logic run_q;
	// A width below one bit leaves nothing to count with
	if (W < 1)
	begin : g_bad_width
		$error("rft_beat_timer needs W of at least 1");
	end
	assign done = run_q && (cnt_q == W'(1));
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end
		else if (load)
		begin
			cnt_q <= count;
			run_q <= 1'b1;
		end
		else if (run_q)
		begin
			cnt_q <= cnt_q - W'(1);
			run_q <= (cnt_q != W'(1));
		end
	end
endmodule // rft_beat_timer

//--- sim/rft_master.sv
// Processor bus master model that issues one transfer and times each beat
`timescale 1ns/1ps
module rft_master (
	input wire logic clk,
	input wire logic ack,
	input wire logic last,
	input wire logic error,
	input wire logic busy,
	input wire logic dev_rd,
	input wire logic dev_wr,
	output logic start,
	output logic sel,
	output logic wr,
	output logic burst,
	output logic [3:0] size
);
	initial
		{start, sel, wr, burst, size} = '0;
	// Burst writes only when a refusal is wanted
	// Socketed block written a byte at a time, soldered one 32 bits at a time
	task automatic xfer(input logic s, input logic w, input logic b, input logic [3:0] z,
		output int g[4], output int n, output logic e, output int h[4]);
		int t;
		int c;
		t = 0;
		n = 0;
		e = 1'b0;
		h = '{0, 0, 0, 0};
		@(posedge clk);
		{start, sel, wr, burst, size} <= {1'b1, s, w, b, z};
		@(posedge clk);
		// Released fields are inverted so a stale value is never mistaken for a live one
		{start, sel, wr, burst, size} <= {1'b0, ~s, ~w, ~b, ~z};
		// Looked at 1 ns after every edge from the take edge on, so the one-cycle error pulse is seen
		for (c = 0; c < 400; c++)
		begin
			#1;
			e = e | (error === 1'b1);
			h[0] += int'(busy === 1'b1);
			h[1] += int'(dev_rd === 1'b1);
			h[2] += int'(dev_wr === 1'b1);
			h[3] += int'(last === 1'b1);
			if (ack === 1'b1 && n < 4)
			begin
				g[n] = t;
				n++;
				t = 0;
				if (last === 1'b1)
					break;
			end
			if (e && t > 3)
				break;
			@(posedge clk);
			t++;
		end
	endtask
endmodule // rft_master

//--- sim/rft_ctrl_tb.sv
// Self-checking bench for the boot ROM/Flash access timing controller
`timescale 1ns/1ps
module rft_ctrl_tb;
	logic clk, rst_n, start, sel, wr, burst, ack, last, error, busy, dev_rd, dev_wr, e;
	logic wide_a = 1'b1, wide_b = 1'b0;
	logic [3:0] size;
	logic [4:0] acc_a = 5'h0c, acc_b = 5'h0c;
	int err_count = 0, n_checks = 0, cyc = 0, n, i, j;
	int g[4];
	int h[4];
	int acc[4] = '{12, 8, 5, 3};
	int f64[4] = '{22, 18, 15, 13};
	int l64[4] = '{16, 12, 9, 7};
	int f16[4] = '{70, 54, 42, 34};
	int l16[4] = '{64, 48, 36, 28};
	rft_ctrl dut (.CLOCK(clk), .RESET_N(rst_n), .START(start), .BLOCK_SEL(sel), .WRITE(wr), .BURST(burst),
		.SIZE(size), .ACC_A(acc_a), .ACC_B(acc_b), .WIDE_A(wide_a), .WIDE_B(wide_b), .BUSY(busy),
		.ACK(ack), .LAST(last), .ERROR(error), .DEV_RD(dev_rd), .DEV_WR(dev_wr));
	rft_master m (.clk(clk), .ack(ack), .last(last), .error(error), .busy(busy), .dev_rd(dev_rd),
		.dev_wr(dev_wr), .start(start), .sel(sel), .wr(wr), .burst(burst), .size(size));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Whole run needs about 1600 cycles; the ceiling leaves ample margin
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_count++;
			finish_test();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch %s expected %0d seen %0d", what, exp, seen);
		end
	endtask
	// One transfer; k beats, first after f clocks, the rest after l clocks each
	task automatic run(input logic s, input logic w, input logic b, input logic [3:0] z, input int k,
		input int f, input int l);
		int tot;
		tot = f + (k - 1) * l;
		m.xfer(s, w, b, z, g, n, e, h);
		check("beats", n, k);
		check("first", g[0], f);
		for (int q = 1; q < k; q++)
			check("later", g[q], l);
		check("busy cycles", h[0], tot);
		check("device read cycles", h[1], w ? 0 : tot);
		check("device write cycles", h[2], w ? tot : 0);
		check("last pulses", h[3], 1);
	endtask
	task automatic test_bursts();
		for (i = 0; i < 4; i++)
		begin
			j = (i + 1) % 4;
			@(posedge clk);
			acc_a <= 5'(acc[i]);
			acc_b <= 5'(acc[j]);
			run(1'b0, 1'b0, 1'b1, 4'h8, 4, f64[i], l64[i]);
			run(1'b1, 1'b0, 1'b1, 4'h8, 4, f16[j], l16[j]);
		end
		// Widths swapped once so each block is seen both wide and narrow
		@(posedge clk);
		wide_a <= 1'b0;
		wide_b <= 1'b1;
		run(1'b0, 1'b0, 1'b1, 4'h8, 4, f16[3], l16[3]);
		run(1'b1, 1'b0, 1'b1, 4'h8, 4, f64[0], l64[0]);
		@(posedge clk);
		wide_a <= 1'b1;
		wide_b <= 1'b0;
		$display("burst read test done");
	endtask
	task automatic test_singles();
		for (i = 0; i < 4; i++)
		begin
			@(posedge clk);
			acc_a <= 5'(acc[i]);
			acc_b <= 5'(acc[i]);
			run(1'b1, 1'b0, 1'b0, 4'h1, 1, f64[i], 0);
			run(1'b1, 1'b0, 1'b0, 4'h8, 1, f16[i], 0);
			run(1'b0, 1'b0, 1'b0, 4'h2, 1, f64[i], 0);
		end
		$display("single read test done");
	endtask
	task automatic test_writes();
		run(1'b0, 1'b1, 1'b0, 4'h4, 1, 21, 0);
		run(1'b1, 1'b1, 1'b0, 4'h1, 1, 21, 0);
		m.xfer(1'b0, 1'b1, 1'b1, 4'h8, g, n, e, h);
		check("refused beats", n, 0);
		check("refusal flag", e, 1'b1);
		check("refused busy", h[0], 0);
		check("refused write cycles", h[2], 0);
		check("refused last", h[3], 0);
		$display("write test done");
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		test_bursts();
		test_singles();
		test_writes();
		finish_test();
	end
endmodule // rft_ctrl_tb
